// ---- rtl/fsrc_ctrl.sv ----
// Host controller for gang lock, suspend/resume, no-op and software reset of a serial flash
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.

// Overview of operation
// - Gang lock sets, gang unlock clears all bits
// - Write enable sent before each gang command
// - Opcodes: eight single-line clocks or two quad
// - Chip select rises only on byte boundary
// - Latency-class commands wait for the suspend latency
// - Exempt commands allowed any time while suspended (here still refused while the post-resume G_OTH hold-off runs)
// - Program inside erase suspend finishes before resume
// - After resume, wait before suspend or others
// - Resume ignored in enhance mode; host exits first (no enhance mode handling here, resume is sent as is)
// - Reset arm then reset, nothing in between
// - Host waits recovery time after software reset
module fsrc_ctrl #(
   parameter int          SUSP_LAT_CYC = fsrc_pkg::SUSP_LAT_CYC,
   parameter int          R2S_CYC      = fsrc_pkg::R2S_CYC,
   parameter int          PGM_CYC      = fsrc_pkg::PGM_CYC,
   parameter int          REC_CYC      = fsrc_pkg::REC_CYC,
   parameter logic [7:0]  SUSPEND_OP   = fsrc_pkg::OP_SUSPEND_DEF,
   parameter int          SCLK_HALF    = fsrc_pkg::SCLK_HALF_CYC
) (
   input  wire logic                         clock,
   input  wire logic                         resetn,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [fsrc_pkg::DATA_W-1:0]  hwdata,
   input  wire logic                         hready,
   output logic                              hreadyout,
   output logic [fsrc_pkg::DATA_W-1:0]       hrdata,
   output logic                              hresp,
   output logic                              cs_n,
   output logic                              sclk,
   output logic [3:0]                        io_out,
   output logic [3:0]                        io_oe,
   input  wire logic [3:0]                   io_in
);
   import fsrc_pkg::*;

   typedef enum logic [1:0] {C_IDLE, C_PRE, C_MAIN} fsrc_c_e;
   typedef struct packed {
      fsrc_c_e                 st;
      logic                    launch;
      logic [7:0]              pre_op;
      logic [7:0]              op;
      logic                    rd;
      logic                    pend;
      logic                    pwr;
      logic [PADDR_W-1:0]      paddr;
      logic                    hready;
      logic                    hresp;
      logic [DATA_W-1:0]       hrdata;
      logic                    quad;
      logic                    susp;
      logic                    refused;
      logic [7:0]              rbyte;
      logic [GATES-1:0][31:0]  g;
      logic [7:0]              prev_op;
   } fsrc_c_s;
   localparam fsrc_c_s C_RST = '{st: C_IDLE, hready: 1'b1, default: '0};

   fsrc_c_s       q;
   fsrc_c_s       d;
   fsrc_shift_if  sh ();

   // True when the flash may take opcode op now
   function automatic logic cmd_ok(input fsrc_c_s s, input logic [7:0] op);
      logic quiet;
      quiet = (s.g[G_ALL] == '0);
      if (op == SUSPEND_OP) begin
         cmd_ok = quiet && (s.g[G_SUS] == '0);
      end else begin
         cmd_ok = quiet && (s.g[G_OTH] == '0) &&
                  (!s.susp || fsrc_exempt(op) || (s.g[G_LAT] == '0)) &&
                  !((op == OP_RESUME) && (s.g[G_RES] != '0));
      end
   endfunction

   // Read value of a register
   function automatic logic [DATA_W-1:0] rd_mux(input fsrc_c_s s);
      logic [DATA_W-1:0] v;
      v = '0;
      case (s.paddr)
         OFF_CMD: begin
            v[CMD_OP_LSB +: 8] = s.op;
            v[CMD_RD_BIT] = s.rd;
         end
         OFF_STAT: begin
            v[STAT_BUSY_BIT] = (s.st != C_IDLE);
            v[STAT_SUSP_BIT] = s.susp;
            v[STAT_REF_BIT] = s.refused;
            v[STAT_GATE_BIT] = (s.g != '0);
            v[STAT_RB_LSB +: 8] = s.rbyte;
         end
         OFF_CTRL: begin
            v[CTRL_QUAD_BIT] = s.quad;
            v[CTRL_PGM_BIT] = (s.g[G_RES] != '0);
         end
         default: v = '0;
      endcase
      rd_mux = v;
   endfunction

   // Next state: bus slave, sequencer and hold-off counters
   always_comb begin
      logic [7:0] wop;
      d = q;
      wop = hwdata[CMD_OP_LSB +: 8];
      d.launch = 1'b0;
      d.hresp = 1'b0;
      // Hold-off counters run down to zero
      for (int i = 0; i < GATES; i++) begin
         if (q.g[i] != '0) begin
            d.g[i] = q.g[i] - 32'd1;
         end
      end
      if (q.launch) begin
         d.prev_op = sh.opcode;
      end
      // Command sequencer
      case (q.st)
         C_IDLE: begin
         end
         C_PRE: begin
            if (sh.done) begin
               d.st = C_MAIN;
               d.launch = 1'b1;
            end
         end
         C_MAIN: begin
            if (sh.done) begin
               d.st = C_IDLE;
               if (q.rd) begin
                  d.rbyte = sh.rdata;
               end
               if (q.op == SUSPEND_OP) begin
                  d.susp = 1'b1;
                  d.g[G_LAT] = 32'(SUSP_LAT_CYC);
               end else if (q.op == OP_RESUME) begin
                  d.susp = 1'b0;
                  d.g[G_SUS] = 32'(R2S_CYC);
                  d.g[G_OTH] = 32'(PGM_CYC);
               end else if (q.op == OP_RST) begin
                  d.susp = 1'b0;
                  d.g[G_ALL] = 32'(REC_CYC);
                  d.quad = 1'b0;
               end
            end
         end
         default: d.st = C_IDLE;
      endcase
      // Bus address phase: one wait state follows
      if (hsel && hready && htrans[1]) begin
         d.pend = 1'b1;
         d.pwr = hwrite;
         d.paddr = haddr[PADDR_W-1:0];
         d.hready = 1'b0;
      end
      // Bus data phase
      if (q.pend) begin
         d.pend = 1'b0;
         d.hready = 1'b1;
         if (!q.pwr) begin
            d.hrdata = rd_mux(q);
         end else if (q.paddr == OFF_CMD) begin
            if (q.st == C_IDLE && cmd_ok(q, wop)) begin
               d.refused = 1'b0;
               d.op = wop;
               d.rd = hwdata[CMD_RD_BIT];
               d.launch = 1'b1;
               if (wop == OP_GANG_LOCK || wop == OP_GANG_UNLOCK) begin
                  d.pre_op = OP_WRITE_ENABLE_CMD;
                  d.st = C_PRE;
               end else if (wop == OP_RST) begin
                  d.pre_op = OP_RST_ARM;
                  d.st = C_PRE;
               end else begin
                  d.st = C_MAIN;
               end
            end else begin
               d.refused = 1'b1;
            end
         end else if (q.paddr == OFF_CTRL) begin
            d.quad = hwdata[CTRL_QUAD_BIT];
            if (hwdata[CTRL_PGM_BIT]) begin
               d.g[G_RES] = 32'(PGM_CYC);
            end
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= C_RST;
      end else begin
         q <= d;
      end
   end

   // opcode framing in either line mode
   assign sh.start  = q.launch;
   assign sh.opcode = (q.st == C_PRE) ? q.pre_op : q.op;
   assign sh.quad   = q.quad;
   assign sh.rd     = q.rd && (q.st == C_MAIN);

   assign hreadyout = q.hready;
   assign hrdata    = q.hrdata;
   assign hresp     = q.hresp;

   // Serial shifter driving the flash pins
   fsrc_shifter #(
      .HALF (SCLK_HALF)
   ) u_shift (
      .clock  (clock),
      .resetn (resetn),
      .sh     (sh),
      .cs_n   (cs_n),
      .sclk   (sclk),
      .io_out (io_out),
      .io_oe  (io_oe),
      .io_in  (io_in)
   );

   sequence s_addr_taken;
      hsel && hready && htrans[1];
   endsequence
   sequence s_wait_then_ready;
      !hreadyout ##1 hreadyout;
   endsequence

   chk_ahb_one_wait: assert property (@(posedge clock) disable iff (!resetn)
      s_addr_taken |=> s_wait_then_ready)
      else $error("bus transfer did not take exactly one wait state");
   chk_ahb_okay: assert property (@(posedge clock) disable iff (!resetn)
      hresp == 1'b0)
      else $error("bus response not OKAY");
   chk_write_enable_cmd_gang: assert property (@(posedge clock) disable iff (!resetn)
      (sh.start && (sh.opcode == OP_GANG_LOCK || sh.opcode == OP_GANG_UNLOCK))
      |-> q.prev_op == OP_WRITE_ENABLE_CMD)
      else $error("gang command sent without write enable before it");
   chk_arm_reset: assert property (@(posedge clock) disable iff (!resetn)
      (sh.start && sh.opcode == OP_RST) |-> q.prev_op == OP_RST_ARM)
      else $error("reset not directly preceded by reset arm");
   chk_reset_recov: assert property (@(posedge clock) disable iff (!resetn)
      sh.start |-> q.g[G_ALL] == '0)
      else $error("command sent during reset recovery");
   chk_resume_susp: assert property (@(posedge clock) disable iff (!resetn)
      (sh.start && sh.opcode == SUSPEND_OP) |-> q.g[G_SUS] == '0)
      else $error("suspend sent too soon after resume");
   chk_resume_oth: assert property (@(posedge clock) disable iff (!resetn)
      (sh.start && q.st == C_MAIN && sh.opcode != SUSPEND_OP) |-> q.g[G_OTH] == '0)
      else $error("command sent before resumed operation could finish");
   chk_susp_latency: assert property (@(posedge clock) disable iff (!resetn)
      (sh.start && q.susp && !fsrc_exempt(sh.opcode)) |-> q.g[G_LAT] == '0)
      else $error("latency-class command sent inside suspend latency");
   chk_resume_block: assert property (@(posedge clock) disable iff (!resetn)
      (sh.start && sh.opcode == OP_RESUME) |-> q.g[G_RES] == '0)
      else $error("resume sent while a suspend-time program runs");
   chk_resume_seq: assert property (@(posedge clock) disable iff (!resetn)
      (q.st == C_MAIN && q.op == OP_RESUME && sh.done) |=> q.g[G_SUS] == 32'(R2S_CYC)
      && !q.susp)
      else $error("resume did not load its hold-off");
endmodule

// ---- rtl/fsrc_pkg.sv ----
// Constants, opcodes, register map and timing for the flash command host controller
package fsrc_pkg;
   localparam int          DATA_W         = 32;
   localparam int          PADDR_W        = 8;
   // Flash opcodes used by the controller
   localparam logic [7:0]  OP_NOP         = 8'h00;
   localparam logic [7:0]  OP_WRITE_ENABLE_CMD        = 8'h06;
   localparam logic [7:0]  OP_WRITE_DISABLE_CMD        = 8'h04;
   localparam logic [7:0]  OP_STAT_RD     = 8'h05;
   localparam logic [7:0]  OP_CFG_RD      = 8'h15;
   localparam logic [7:0]  OP_SEC_RD      = 8'h2b;
   localparam logic [7:0]  OP_ID_RES      = 8'hab;
   localparam logic [7:0]  OP_RST_ARM     = 8'h66;
   localparam logic [7:0]  OP_RST         = 8'h99;
   localparam logic [7:0]  OP_GANG_LOCK   = 8'h7e;
   localparam logic [7:0]  OP_GANG_UNLOCK = 8'h98;
   localparam logic [7:0]  OP_RESUME      = 8'h30;
   localparam logic [7:0]  OP_SUSPEND_DEF = 8'hb0;
   // Register offsets
   localparam logic [7:0]  OFF_CMD        = 8'h00;
   localparam logic [7:0]  OFF_STAT       = 8'h04;
   localparam logic [7:0]  OFF_CTRL       = 8'h08;
   // Field positions
   localparam int          CMD_OP_LSB     = 0;
   localparam int          CMD_RD_BIT     = 8;
   localparam int          CTRL_QUAD_BIT  = 0;
   localparam int          CTRL_PGM_BIT   = 1;
   localparam int          STAT_BUSY_BIT  = 0;
   localparam int          STAT_SUSP_BIT  = 1;
   localparam int          STAT_REF_BIT   = 2;
   localparam int          STAT_GATE_BIT  = 3;
   localparam int          STAT_RB_LSB    = 8;
   // Hold-off counter slots
   localparam int          G_ALL          = 0;
   localparam int          G_OTH          = 1;
   localparam int          G_LAT          = 2;
   localparam int          G_SUS          = 3;
   localparam int          G_RES          = 4;
   localparam int          GATES          = 5;
   // Timing: times in ns, counts rounded up to whole clock cycles
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          SUSP_LAT_NS    = 20000;
   localparam int          R2S_NS         = 100000;
   localparam int          PGM_NS         = 1000000;
   localparam int          REC_NS         = 1000000;
   localparam int          SUSP_LAT_CYC   = (SUSP_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          R2S_CYC        = (R2S_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          PGM_CYC        = (PGM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          REC_CYC        = (REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SCLK_HALF_CYC  = 4;

   // Commands the flash takes at any time while suspended
   function automatic logic fsrc_exempt(input logic [7:0] op);
      fsrc_exempt = (op == OP_WRITE_DISABLE_CMD) || (op == OP_STAT_RD) || (op == OP_CFG_RD) ||
                    (op == OP_SEC_RD) || (op == OP_ID_RES) || (op == OP_RST_ARM) ||
                    (op == OP_RST) || (op == OP_NOP);
   endfunction
endpackage

// ---- rtl/fsrc_shift_if.sv ----
// Request and answer signals between the command sequencer and the serial shifter
interface fsrc_shift_if;
   logic        start;
   logic [7:0]  opcode;
   logic        quad;
   logic        rd;
   logic        busy;
   logic        done;
   logic [7:0]  rdata;
   modport ctrl    (output start, opcode, quad, rd, input busy, done, rdata);
   modport shifter (input start, opcode, quad, rd, output busy, done, rdata);
endinterface

// ---- rtl/fsrc_shifter.sv ----
// Serial shifter: frames one opcode, optionally reads one byte, mode 0 clocking
module fsrc_shifter #(
   parameter int HALF = fsrc_pkg::SCLK_HALF_CYC
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   fsrc_shift_if.shifter    sh,
   output logic             cs_n,
   output logic             sclk,
   output logic [3:0]       io_out,
   output logic [3:0]       io_oe,
   input  wire logic [3:0]  io_in
);
   import fsrc_pkg::*;

   typedef enum logic [1:0] {SH_IDLE, SH_RUN, SH_GAP} fsrc_sh_e;
   typedef struct packed {
      fsrc_sh_e    st;
      logic [7:0]  div;
      logic [4:0]  beat;
      logic [4:0]  tx_beats;
      logic [4:0]  total;
      logic        quad;
      logic [7:0]  sr;
      logic [7:0]  rdata;
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic        cs_n;
      logic        sclk;
      logic [3:0]  io_out;
      logic [3:0]  io_oe;
      logic        done;
   } fsrc_sh_s;
   localparam fsrc_sh_s SH_RST = '{st: SH_IDLE, cs_n: 1'b1, default: '0};

   fsrc_sh_s q;
   fsrc_sh_s d;

   // Next state of the shifter
   always_comb begin
      d = q;
      d.s1 = io_in;
      d.s2 = q.s1;
      d.done = 1'b0;
      case (q.st)
         SH_IDLE: begin
            if (sh.start) begin
               d.st = SH_RUN;
               d.cs_n = 1'b0;
               d.div = '0;
               d.beat = '0;
               d.quad = sh.quad;
               d.sr = sh.opcode;
               d.rdata = '0;
               d.tx_beats = sh.quad ? 5'd2 : 5'd8;
               d.total = sh.quad ? (sh.rd ? 5'd4 : 5'd2) : (sh.rd ? 5'd16 : 5'd8);
               d.io_out = sh.quad ? sh.opcode[7:4] : {3'b000, sh.opcode[7]};
               d.io_oe = sh.quad ? 4'hf : 4'h1;
            end
         end
         SH_RUN: begin
            if (q.div == 8'(HALF - 1)) begin
               d.div = '0;
               d.sclk = !q.sclk;
               if (!q.sclk) begin
                  // Rising edge: count beat, sample read data
                  d.beat = q.beat + 5'd1;
                  if (q.beat >= q.tx_beats) begin
                     d.rdata = q.quad ? {q.rdata[3:0], q.s2} : {q.rdata[6:0], q.s2[1]};
                  end
               end else if (q.beat == q.total) begin
                  d.st = SH_GAP;
                  d.cs_n = 1'b1;
                  d.io_oe = 4'h0;
                  d.io_out = 4'h0;
               end else if (q.beat == q.tx_beats) begin
                  d.io_oe = 4'h0;
                  d.io_out = 4'h0;
               end else begin
                  d.sr = q.quad ? {q.sr[3:0], 4'h0} : {q.sr[6:0], 1'b0};
                  d.io_out = q.quad ? q.sr[3:0] : {3'b000, q.sr[6]};
               end
            end else begin
               d.div = q.div + 8'd1;
            end
         end
         SH_GAP: begin
            if (q.div == 8'(HALF - 1)) begin
               d.st = SH_IDLE;
               d.div = '0;
               d.done = 1'b1;
            end else begin
               d.div = q.div + 8'd1;
            end
         end
         default: d = SH_RST;
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= SH_RST;
      end else begin
         q <= d;
      end
   end

   assign cs_n     = q.cs_n;
   assign sclk     = q.sclk;
   assign io_out   = q.io_out;
   assign io_oe    = q.io_oe;
   assign sh.busy  = (q.st != SH_IDLE);
   assign sh.done  = q.done;
   assign sh.rdata = q.rdata;

   chk_cs_byte_edge: assert property (@(posedge clock) disable iff (!resetn)
      $rose(cs_n) |-> ($past(q.beat) == $past(q.total)) && !sclk)
      else $error("chip select rose off a byte boundary");
   chk_quad_lines: assert property (@(posedge clock) disable iff (!resetn)
      (q.st == SH_RUN && q.quad && q.beat < q.tx_beats) |-> io_oe == 4'hf)
      else $error("quad opcode not driven on four lines");
   chk_single_line: assert property (@(posedge clock) disable iff (!resetn)
      (q.st == SH_RUN && !q.quad && q.beat < q.tx_beats) |-> io_oe == 4'h1)
      else $error("single-line opcode drove upper lines");
endmodule

// ---- tb/fsrc_flash_model.sv ----
// Behavioural serial flash that logs opcode frames and answers a status read
module fsrc_flash_model #(
   parameter logic [7:0] PSEL_OP = 8'h68 // Protect mode select opcode, value arbitrary
) (
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe,
   output logic      [3:0] io_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh, rd_q, op_log [0:31];
   int         nbits, nclk, nfr = 0, clk_log [0:31];
   logic       write_enable_latch = 0, dynamic_protect_bit = 1, armed = 0, psel = 0, dbit = 0, tgl = 0;
   // Idle or released lines show no stale value
   assign io_in = {tgl, tgl, cs_n ? ~dbit : dbit, tgl};
   // Frame start loads the status byte
   always @(negedge cs_n) begin
      nbits = 0;
      nclk = 0;
      rd_q = {dynamic_protect_bit, 5'h0, write_enable_latch, 1'b0};
   end
   // opcode capture: one line, or four in quad mode
   always @(posedge sclk) begin
      tgl = ~tgl;
      if (io_oe[3]) sh = {sh[3:0], io_out};
      else if (io_oe[0]) sh = {sh[6:0], io_out[0]};
      if (io_oe != 4'h0) begin
         nclk++;
         nbits += io_oe[3] ? 4 : 1;
      end
   end
   // Status byte out on falling clock, MSB first
   always @(negedge sclk) if (nbits == 8 && sh == 8'h05) begin
      dbit = rd_q[7];
      rd_q = rd_q << 1;
   end
   // Frame end logs and acts on the opcode
   always @(posedge cs_n) if (nclk > 0) begin
      op_log[nfr] = sh;
      clk_log[nfr] = nclk;
      nfr++;
      // byte boundary: partial bytes are dropped
      if (nbits == 8) begin
         // reset also sets the protect bit and clears latch and mode select
         if (sh == 8'h99 && armed) begin
            dynamic_protect_bit = 1;
            write_enable_latch = 0;
            psel = 0;
         end
         // gang needs mode select and latch
         if (psel && write_enable_latch && sh == 8'h7e) dynamic_protect_bit = 1;
         if (psel && write_enable_latch && sh == 8'h98) dynamic_protect_bit = 0;
         if (sh == PSEL_OP) psel = 1;
         // latch set by enable and resume
         // suspend and gang clear the latch
         if (sh == 8'h06 || sh == 8'h30) write_enable_latch = 1;
         else if (sh inside {8'h04, 8'h7e, 8'h98, 8'hb0}) write_enable_latch = 0;
         // arm lasts one frame, no-op cancels it
         armed = (sh == 8'h66);
      end
   end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the flash command host controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fsrc_pkg::*;
   localparam logic [7:0] PSEL = 8'h68;
   logic        clock = 0, resetn = 0, hsel = 0, hwrite = 0, hready;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, cs_n, sclk;
   logic [3:0]  io_out, io_oe, io_in;
   int          fails = 0, cmp_count = 0;
   // Single slave drives the bus ready
   assign hready = hreadyout;
   always #20 clock = ~clock;
   fsrc_ctrl #(.SUSP_LAT_CYC(40), .R2S_CYC(30), .PGM_CYC(60), .REC_CYC(40),
      .SUSPEND_OP(OP_SUSPEND_DEF), .SCLK_HALF(4)) u_dut (.clock(clock), .resetn(resetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .cs_n(cs_n), .sclk(sclk), .io_out(io_out), .io_oe(io_oe),
      .io_in(io_in));
   fsrc_flash_model #(.PSEL_OP(PSEL)) u_flash (.cs_n(cs_n), .sclk(sclk), .io_out(io_out),
      .io_oe(io_oe), .io_in(io_in));
   // Compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One AHB single transfer, address phase then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 0);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string s);
      xfer(0, a, 0);
      check(s, rd & m, e);
   endtask
   // Poll status until the masked bits are clear
   task automatic idle(input logic [31:0] m);
      int n;
      n = 0;
      do begin
         xfer(0, OFF_STAT, 0);
         n++;
      end while ((rd & m) !== 0 && n < 300);
      // A poll that runs out counts as a mismatch
      if (n >= 300) fails++;
   endtask
   task automatic cmd(input logic [31:0] op);
      xfer(1, OFF_CMD, op);
      idle(32'h1);
   endtask
   task automatic fr(input int i, input logic [7:0] op, input int clks);
      check("frame opcode", u_flash.op_log[i], op);
      check("frame clocks", u_flash.clk_log[i], clks);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   initial begin
      #400us;
      fails++;
      test_done();
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clock);
      resetn <= 1;
      @(posedge clock);
      rd_chk(OFF_STAT, 32'hf, 0, "status at reset");
      xfer(1, 8'h0c, 32'hffff_ffff);
      rd_chk(8'h0c, 32'hffff_ffff, 0, "unmapped");
      cmd(OP_NOP);
      fr(0, OP_NOP, 8);
      cmd(OP_GANG_UNLOCK);
      fr(1, OP_WRITE_ENABLE_CMD, 8);
      fr(2, OP_GANG_UNLOCK, 8);
      check("dpb before select", u_flash.dynamic_protect_bit, 1);
      cmd(PSEL);
      cmd(OP_GANG_UNLOCK);
      check("dpb unlocked", u_flash.dynamic_protect_bit, 0);
      // Quad command mode: two clocks per opcode
      xfer(1, OFF_CTRL, 1);
      cmd(OP_GANG_LOCK);
      fr(6, OP_WRITE_ENABLE_CMD, 2);
      fr(7, OP_GANG_LOCK, 2);
      check("dpb locked", u_flash.dynamic_protect_bit, 1);
      cmd(OP_RST_ARM);
      cmd(OP_NOP);
      check("arm cancelled", u_flash.armed, 0);
      cmd(OP_GANG_UNLOCK);
      cmd(OP_RST);
      fr(12, OP_RST_ARM, 2);
      fr(13, OP_RST, 2);
      check("dpb after reset", u_flash.dynamic_protect_bit, 1);
      rd_chk(OFF_CTRL, 32'h1, 0, "quad after reset");
      xfer(1, OFF_CMD, OP_NOP);
      rd_chk(OFF_STAT, 32'hc, 32'hc, "recovery hold");
      check("frames in recovery", u_flash.nfr, 14);
      idle(32'h9);
      // Suspend, then latency-class and exempt commands
      cmd(OP_SUSPEND_DEF);
      rd_chk(OFF_STAT, 32'h6, 32'h2, "suspended");
      xfer(1, OFF_CMD, 8'h03);
      rd_chk(OFF_STAT, 32'h4, 32'h4, "read in latency");
      cmd(32'h105);
      rd_chk(OFF_STAT, 32'hff04, 32'h8000, "status byte");
      idle(32'h9);
      cmd(OP_RESUME);
      xfer(1, OFF_CMD, OP_SUSPEND_DEF);
      rd_chk(OFF_STAT, 32'h6, 32'h4, "resume then suspend");
      idle(32'h9);
      // Program inside erase suspend blocks resume
      cmd(OP_SUSPEND_DEF);
      idle(32'h9);
      xfer(1, OFF_CTRL, 2);
      rd_chk(OFF_CTRL, 32'h2, 32'h2, "program running");
      xfer(1, OFF_CMD, OP_RESUME);
      rd_chk(OFF_STAT, 32'h6, 32'h6, "resume blocked");
      idle(32'h9);
      rd_chk(OFF_CTRL, 32'h2, 0, "program done");
      cmd(OP_RESUME);
      rd_chk(OFF_STAT, 32'h6, 0, "resumed");
      test_done();
   end
endmodule
